// ---- rtl/srsf_top.sv ----
/*
  Status flags of one serial channel with its shift paths, holding
  registers, read-then-write flag clearing and a masked interrupt.
  Assumes a bit strobe from an outside rate generator and a plain
  register port with read data one cycle after the read strobe.
*/
// What this block does
// - transmit empty flag is forced to one while transmit is disabled.
// - moving holding byte into transmit shifter sets transmit empty flag.
// - receive full flag clears by zero write after reading it as one, or controller read.
// - transfer controller read of receive holding register clears full flag.
// - good reception copies byte to holding register and sets full flag.
// - error or receive disable leaves holding register and full flag alone.
// - reception completing while full flag is one sets overrun flag.
// - on overrun the old byte stays, the new byte is dropped.
// - overrun flag resets to zero, clears by zero write after read.
// - clearing receive enable leaves the overrun flag untouched.
// - reception halts while the overrun flag is one.
// - synchronous mode transmission halts while the overrun flag is one.
// - receive full flag reads zero after reset.
// - framing errors are flagged only for asynchronous receptions.
// - empty flag clears by zero write after read, or controller write.
// - framing error when first stop bit samples as zero.
`timescale 1ns/10ps
`default_nettype none
`include "srsf_map.svh"

module srsf_top (
  input  wire logic       I_CLK_SYS,  // 100 MHz system clock
  input  wire logic       I_RST,      // async reset, active high
  input  wire logic [7:0] I_ADDR,     // register offset
  input  wire logic [7:0] I_WDATA,    // write data
  input  wire logic       I_WR,       // write strobe
  input  wire logic       I_RD,       // read strobe
  input  wire logic       I_XFER,     // access made by transfer ctrl
  input  wire logic       I_BIT_TICK, // one pulse per bit time
  input  wire logic       I_RXD,      // serial receive line
  output logic      [7:0] O_RDATA,    // read data, cycle after read
  output logic            O_TXD,      // serial transmit line
  output logic            O_RX_REQ,   // receive full request
  output logic            O_TX_REQ,   // transmit empty request
  output logic            O_IRQ       // level interrupt
);
  import srsf_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // state
  logic [3:0]  ctrl_q;
  srsf_flags_t flg_q, flg_d;
  srsf_flags_t arm_q;
  logic [7:0]  rdr_q, tdr_q;
  logic [3:0]  istat_q, imask_q;
  logic [7:0]  rdata_q;
  srsf_tx_t    tx_st_q;
  logic [10:0] tsr_q;
  logic [3:0]  tx_cnt_q, tx_len_q;
  logic        txd_q;
  logic        rx_done, rx_stop;
  logic [7:0]  rx_data;

  ////////////////////////////////////////////////////////////////////
  // address decode
  wire hit_ctrl  = (I_ADDR == `SRSF_OFS_CTRL);
  wire hit_stat  = (I_ADDR == `SRSF_OFS_STAT);
  wire hit_rxd   = (I_ADDR == `SRSF_OFS_RXD);
  wire hit_txd   = (I_ADDR == `SRSF_OFS_TXD);
  wire hit_istat = (I_ADDR == `SRSF_OFS_ISTAT);
  wire hit_imask = (I_ADDR == `SRSF_OFS_IMASK);

  wire stat_rd = I_RD & hit_stat;
  wire stat_wr = I_WR & hit_stat;
  wire te      = ctrl_q[`SRSF_CTL_TE];
  wire re      = ctrl_q[`SRSF_CTL_RE];
  wire sync_md = ctrl_q[`SRSF_CTL_SYNC];
  wire stop2   = ctrl_q[`SRSF_CTL_STOP2];
  wire transmit_buffer_empty_flag    = flg_q[`SRSF_FL_TRANSMIT_BUFFER_EMPTY_FLAG];
  wire receive_buffer_full_flag    = flg_q[`SRSF_FL_RECEIVE_BUFFER_FULL_FLAG];
  wire overrun_flag    = flg_q[`SRSF_FL_OVERRUN_FLAG];
  wire framing_error_flag     = flg_q[`SRSF_FL_FER];

  // read mux; unmapped offsets read as zero
  wire [7:0] rd_mux =
    hit_ctrl  ? {4'h0, ctrl_q} :
    hit_stat  ? {flg_q, 4'h0} :
    hit_rxd   ? rdr_q :
    hit_txd   ? tdr_q :
    hit_istat ? {4'h0, istat_q} :
    hit_imask ? {4'h0, imask_q} : 8'h00;

  // data stands one cycle only, zero otherwise
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= I_RD ? rd_mux : 8'h00;
    end
  end
  assign O_RDATA = rdata_q;

  ////////////////////////////////////////////////////////////////////
  // receive path; halted by a pending error so no byte is half-lost
  // halt on overrun
  wire rx_en = re & ~overrun_flag & ~framing_error_flag;

  srsf_rx_shift u_rx (
    .i_clk  (I_CLK_SYS),
    .i_rst  (I_RST),
    .i_en   (rx_en),
    .i_sync (sync_md),
    .i_tick (I_BIT_TICK),
    .i_rxd  (I_RXD),
    .o_done (rx_done),
    .o_data (rx_data),
    .o_stop (rx_stop)
  );

  wire fer_set  = rx_done & ~sync_md & ~rx_stop;
  wire overrun_flag_set = rx_done & receive_buffer_full_flag;
  wire rx_ok    = rx_done & ~receive_buffer_full_flag & ~fer_set;

  ////////////////////////////////////////////////////////////////////
  // transmit path
  // sync transmit halts on overrun
  wire tx_stall = sync_md & overrun_flag;
  wire tx_load  = te & ~transmit_buffer_empty_flag & (tx_st_q == TX_IDLE) & ~tx_stall;
  wire [3:0] frame_len = sync_md ? `SRSF_TX_SYNC :
                         stop2   ? `SRSF_TX_ASYNC2 : `SRSF_TX_ASYNC1;
  // sync frames carry no start bit, so data goes out from bit 0
  wire [10:0] frame = sync_md ? {3'h7, tdr_q} : {2'h3, tdr_q, 1'b0};

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      tx_st_q  <= TX_IDLE;
      tsr_q    <= 11'h7ff;
      tx_cnt_q <= 4'h0;
      tx_len_q <= 4'h0;
      txd_q    <= 1'b1;
    end else if (!te) begin
      tx_st_q <= TX_IDLE;
      txd_q   <= 1'b1;
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          if (tx_load) begin
            tsr_q    <= frame;
            tx_cnt_q <= 4'h0;
            tx_len_q <= frame_len;
            tx_st_q  <= TX_SHIFT;
          end
        end
        default: begin
          if (I_BIT_TICK && !tx_stall) begin
            txd_q    <= tsr_q[0];
            tsr_q    <= {1'b1, tsr_q[10:1]};
            tx_cnt_q <= tx_cnt_q + 4'h1;
            if (tx_cnt_q == tx_len_q - 4'h1) begin
              tx_st_q <= TX_IDLE;
            end
          end
        end
      endcase
    end
  end
  assign O_TXD = txd_q;

  ////////////////////////////////////////////////////////////////////
  // flag clearing: a status read arms each bit that read as one,
  // and of the status writes only a zero write to an armed bit clears it
  wire [3:0] wr_zero = ~I_WDATA[7:`SRSF_ST_LSB];
  wire [3:0] sw_clr  = {4{stat_wr}} & wr_zero & arm_q;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_arm
      // arm only from a read of one
      always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
          arm_q[gi] <= 1'b0;
        end else if (stat_rd) begin
          arm_q[gi] <= flg_q[gi];
        end else if (sw_clr[gi]) begin
          arm_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // transfer controller side effects
  // controller read clears full
  wire xfer_rd  = I_XFER & I_RD & hit_rxd & receive_buffer_full_flag;
  wire xfer_wr  = I_XFER & I_WR & hit_txd & transmit_buffer_empty_flag;
  wire receive_buffer_full_flag_clr = sw_clr[`SRSF_FL_RECEIVE_BUFFER_FULL_FLAG] | xfer_rd;
  wire transmit_buffer_empty_flag_clr = sw_clr[`SRSF_FL_TRANSMIT_BUFFER_EMPTY_FLAG] | xfer_wr;

  // setting always beats clearing in the same cycle
  always_comb begin
    flg_d = flg_q;
    if (~te | tx_load) begin
      flg_d[`SRSF_FL_TRANSMIT_BUFFER_EMPTY_FLAG] = 1'b1;
    end else if (transmit_buffer_empty_flag_clr) begin
      flg_d[`SRSF_FL_TRANSMIT_BUFFER_EMPTY_FLAG] = 1'b0;
    end
    if (rx_ok) begin
      flg_d[`SRSF_FL_RECEIVE_BUFFER_FULL_FLAG] = 1'b1;
    end else if (receive_buffer_full_flag_clr) begin
      flg_d[`SRSF_FL_RECEIVE_BUFFER_FULL_FLAG] = 1'b0;
    end
    if (overrun_flag_set) begin
      flg_d[`SRSF_FL_OVERRUN_FLAG] = 1'b1;
    end else if (sw_clr[`SRSF_FL_OVERRUN_FLAG]) begin
      flg_d[`SRSF_FL_OVERRUN_FLAG] = 1'b0;
    end
    if (fer_set) begin
      flg_d[`SRSF_FL_FER] = 1'b1;
    end else if (sw_clr[`SRSF_FL_FER]) begin
      flg_d[`SRSF_FL_FER] = 1'b0;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      flg_q <= `SRSF_FLAG_RST;
    end else begin
      flg_q <= flg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // holding registers and control
  // old byte kept on overrun
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      rdr_q  <= 8'h00;
      tdr_q  <= 8'h00;
      ctrl_q <= `SRSF_CTRL_RST;
    end else begin
      if (rx_ok) begin
        rdr_q <= rx_data;
      end
      if (I_WR && hit_txd) begin
        tdr_q <= I_WDATA;
      end
      if (I_WR && hit_ctrl) begin
        ctrl_q <= I_WDATA[3:0];
      end
    end
  end

  assign O_RX_REQ = receive_buffer_full_flag;
  assign O_TX_REQ = transmit_buffer_empty_flag & te;

  ////////////////////////////////////////////////////////////////////
  // interrupt: sticky events, write one to clear, set wins
  wire [3:0] ev;
  assign ev[`SRSF_EV_RXF] = rx_ok;
  assign ev[`SRSF_EV_OVR] = overrun_flag_set;
  assign ev[`SRSF_EV_FER] = fer_set;
  assign ev[`SRSF_EV_TXE] = tx_load;
  wire [3:0] ist_clr = (I_WR && hit_istat) ? I_WDATA[3:0] : 4'h0;

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      istat_q <= `SRSF_IRQ_RST;
      imask_q <= `SRSF_IRQ_RST;
    end else begin
      istat_q <= ev | (istat_q & ~ist_clr);
      if (I_WR && hit_imask) begin
        imask_q <= I_WDATA[3:0];
      end
    end
  end
  assign O_IRQ = |(istat_q & imask_q);

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);

  sequence s_receive_buffer_full_flag_armed;
    stat_rd && receive_buffer_full_flag;
  endsequence
  sequence s_zero_write;
    stat_wr && !I_WDATA[6] && !stat_rd;
  endsequence

  transmit_buffer_empty_flag_forced_a: assert property (!te |=> transmit_buffer_empty_flag)
    else $error("empty flag low while transmit disabled");

  load_sets_a: assert property (tx_load |=> transmit_buffer_empty_flag && tx_st_q == TX_SHIFT)
    else $error("shifter load did not set empty flag");

  receive_buffer_full_flag_clear_a: assert property (s_receive_buffer_full_flag_armed ##1 s_zero_write |=> !receive_buffer_full_flag)
    else $error("armed zero write failed to clear full flag");

  receive_buffer_full_flag_cause_a: assert property ($fell(receive_buffer_full_flag) |-> $past(receive_buffer_full_flag_clr))
    else $error("full flag fell without a clear");

  rx_good_a: assert property (rx_ok |=> receive_buffer_full_flag && rdr_q == $past(rx_data))
    else $error("good reception not stored");

  err_hold_a: assert property (rx_done && (receive_buffer_full_flag || fer_set) |=> $stable(rdr_q))
    else $error("holding register changed on error");

  overrun_set_a: assert property (rx_done && receive_buffer_full_flag
    |=> overrun_flag && (receive_buffer_full_flag || $past(receive_buffer_full_flag_clr)))
    else $error("overrun not flagged");

  overrun_flag_cause_a: assert property ($fell(overrun_flag) |-> $past(sw_clr[1]))
    else $error("overrun flag fell without armed clear");

  rx_halt_a: assert property (overrun_flag |-> !rx_en ##1 !rx_done)
    else $error("reception ran during overrun");

  tx_halt_a: assert property (tx_stall && te |=> $stable(tx_cnt_q))
    else $error("sync transmit moved during overrun");

  fer_async_a: assert property ($rose(framing_error_flag)
    |-> $past(rx_done) && !$past(sync_md))
    else $error("framing error outside async reception");

  write_one_a: assert property (stat_wr && I_WDATA[6] && receive_buffer_full_flag && !xfer_rd |=> receive_buffer_full_flag)
    else $error("write of one cleared full flag");

endmodule
`default_nettype wire

// ---- pkg/srsf_map.svh ----
/*
  Register offsets, field positions, reset values and frame counts
  for the serial receive status flag block.
  Assumes the includer uses the names only; it holds no logic.
*/
`ifndef SRSF_MAP_SVH
`define SRSF_MAP_SVH

// register offsets on the 8-bit address port
`define SRSF_OFS_CTRL  8'h00
`define SRSF_OFS_STAT  8'h04
`define SRSF_OFS_RXD   8'h08
`define SRSF_OFS_TXD   8'h0c
`define SRSF_OFS_ISTAT 8'h10
`define SRSF_OFS_IMASK 8'h14

// control register fields
`define SRSF_CTL_TE    0
`define SRSF_CTL_RE    1
`define SRSF_CTL_SYNC  2
`define SRSF_CTL_STOP2 3
`define SRSF_CTRL_RST  4'h0

// status register: flags sit in bits 7..4, low nibble reads zero
`define SRSF_ST_LSB    4
`define SRSF_FL_TRANSMIT_BUFFER_EMPTY_FLAG   3
`define SRSF_FL_RECEIVE_BUFFER_FULL_FLAG   2
`define SRSF_FL_OVERRUN_FLAG   1
`define SRSF_FL_FER    0
`define SRSF_FLAG_RST  4'h8

// interrupt status and mask fields
`define SRSF_EV_RXF    0
`define SRSF_EV_OVR    1
`define SRSF_EV_FER    2
`define SRSF_EV_TXE    3
`define SRSF_IRQ_RST   4'h0

// last receive data bit index, and frame lengths in bit times
`define SRSF_DATA_LAST 3'd7
`define SRSF_TX_SYNC   4'd8
`define SRSF_TX_ASYNC1 4'd10
`define SRSF_TX_ASYNC2 4'd11

`endif

// ---- pkg/srsf_pkg.sv ----
/*
  Types shared by the serial receive status flag block.
  Assumes srsf_map.svh provides the numeric constants.
*/
package srsf_pkg;
  // receive shift path states
  typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_STOP} srsf_rx_t;
  // transmit shift path states
  typedef enum logic {TX_IDLE, TX_SHIFT} srsf_tx_t;
  // flag index vector: transmit_buffer_empty_flag, receive_buffer_full_flag, overrun_flag, fer
  typedef logic [3:0] srsf_flags_t;
endpackage

// ---- rtl/srsf_rx_shift.sv ----
/*
  Receive shift register: collects one 8-bit character, lsb first.
  Assumes i_tick pulses once per bit, near the bit centre.
*/
`timescale 1ns/10ps
`default_nettype none
`include "srsf_map.svh"

module srsf_rx_shift (
  input  wire logic       i_clk,   // system clock
  input  wire logic       i_rst,   // async reset, active high
  input  wire logic       i_en,    // reception allowed
  input  wire logic       i_sync,  // clocked synchronous mode
  input  wire logic       i_tick,  // bit sample strobe
  input  wire logic       i_rxd,   // serial input
  output logic            o_done,  // character complete, one cycle
  output logic [7:0]      o_data,  // received character
  output logic            o_stop   // first stop bit seen
);
  import srsf_pkg::*;

  srsf_rx_t  st_q;
  logic [2:0] cnt_q;
  logic [7:0] sh_q;
  wire  [7:0] sh_nx = {i_rxd, sh_q[7:1]};

  // dropping i_en aborts a half-received character
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q   <= RX_IDLE;
      cnt_q  <= 3'h0;
      sh_q   <= 8'h00;
      o_done <= 1'b0;
      o_data <= 8'h00;
      o_stop <= 1'b1;
    end else if (!i_en) begin
      st_q   <= RX_IDLE;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_tick) begin
        case (st_q)
          RX_IDLE: begin
            if (i_sync) begin
              sh_q  <= sh_nx;
              cnt_q <= 3'h1;
              st_q  <= RX_DATA;
            end else if (!i_rxd) begin
              cnt_q <= 3'h0;
              st_q  <= RX_DATA;
            end
          end
          RX_DATA: begin
            sh_q  <= sh_nx;
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == `SRSF_DATA_LAST) begin
              if (i_sync) begin
                o_data <= sh_nx;
                o_stop <= 1'b1;
                o_done <= 1'b1;
                st_q   <= RX_IDLE;
              end else begin
                st_q <= RX_STOP;
              end
            end
          end
          // only the first stop bit is looked at
          default: begin
            o_data <= sh_q;
            o_stop <= i_rxd;
            o_done <= 1'b1;
            st_q   <= RX_IDLE;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ---- bench/srsf_line_model.sv ----
/*
  Far end of the serial receive line: makes the bit strobe and sends
  one asynchronous or clocked synchronous character on request.
  Assumes one system clock and an active high asynchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none

module srsf_line_model (
  input  wire logic       i_clk,   // system clock
  input  wire logic       i_rst,   // async reset, active high
  input  wire logic       i_send,  // start one character
  input  wire logic [7:0] i_byte,  // character to send
  input  wire logic       i_stop,  // stop bit level, async only
  input  wire logic       i_sync,  // clocked synchronous framing
  output logic            o_tick,  // bit strobe, only within frames
  output logic            o_rxd,   // serial line, idles high
  output logic            o_busy   // frame in progress
);
  logic [1:0]  div_q;
  logic [10:0] frame_q;
  logic [3:0]  left_q;

  ////////////////////////////////////////////////////////////////////
  // strobe stands still between frames, so a synchronous receiver
  // never sees phantom characters; the first bit is on the line
  // before the first strobe samples it
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_q   <= 2'h0;
      o_tick  <= 1'b0;
      o_rxd   <= 1'b1;
      o_busy  <= 1'b0;
      frame_q <= 11'h7ff;
      left_q  <= 4'h0;
    end else begin
      div_q  <= div_q + 2'h1;
      o_tick <= o_busy && (div_q == 2'h3);
      if (i_send && !o_busy) begin
        o_busy  <= 1'b1;
        o_rxd   <= i_sync ? i_byte[0] : 1'b0;
        frame_q <= i_sync ? {4'hf, i_byte[7:1]} : {2'h3, i_stop, i_byte};
        left_q  <= i_sync ? 4'h7 : 4'h9;
      end else if (o_tick) begin
        if (left_q != 4'h0) begin
          o_rxd   <= frame_q[0];
          frame_q <= {1'b1, frame_q[10:1]};
          left_q  <= left_q - 4'h1;
        end else begin
          o_rxd  <= 1'b1;
          o_busy <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- bench/srsf_top_tb_top.sv ----
/*
  Self-checking bench for the serial status flag block: register
  reads and writes, serial characters from the line model, flag checks.
  Assumes read data one cycle after the read strobe and no stalls.
*/
`timescale 1ns/10ps
`default_nettype none
`include "srsf_map.svh"

module srsf_top_tb_top;
  logic       I_CLK_SYS = 1'b0;
  logic       I_RST     = 1'b1;
  logic       I_WR      = 1'b0;
  logic       I_RD      = 1'b0;
  logic       I_XFER    = 1'b0;
  logic [7:0] I_ADDR    = 8'h00;
  logic [7:0] I_WDATA   = 8'h00;
  logic       send      = 1'b0;
  logic       stop      = 1'b1;
  logic       sync      = 1'b0;
  logic [7:0] tx_byte   = 8'h00;
  logic       tick_d    = 1'b0;
  logic [7:0] txd_sh    = 8'h00;
  wire logic  I_BIT_TICK, I_RXD, busy;
  wire logic  O_TXD, O_RX_REQ, O_TX_REQ, O_IRQ;
  wire logic [7:0] O_RDATA;
  int n_fail  = 0;
  int checked = 0;

  always #5 I_CLK_SYS = ~I_CLK_SYS;

  // transmit line bits, taken the cycle after each strobe shifts one
  always @(posedge I_CLK_SYS) begin
    tick_d <= I_BIT_TICK;
    if (tick_d) begin
      txd_sh <= {O_TXD, txd_sh[7:1]};
    end
  end

  srsf_top uut (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .I_XFER(I_XFER),
    .I_BIT_TICK(I_BIT_TICK), .I_RXD(I_RXD), .O_RDATA(O_RDATA),
    .O_TXD(O_TXD), .O_RX_REQ(O_RX_REQ), .O_TX_REQ(O_TX_REQ),
    .O_IRQ(O_IRQ));

  srsf_line_model line (.i_clk(I_CLK_SYS), .i_rst(I_RST), .i_send(send),
    .i_byte(tx_byte), .i_stop(stop), .i_sync(sync), .o_tick(I_BIT_TICK),
    .o_rxd(I_RXD), .o_busy(busy));

  ////////////////////////////////////////////////////////////////////
  // verdict in one place, reached by the tests or the watchdog
  task automatic finish_test;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // one-cycle strobes; #1 lets the edge's updates land before sampling
  task automatic wr(input logic [7:0] a, d, input logic x = 1'b0);
    @(posedge I_CLK_SYS);
    I_WR <= 1'b1; I_ADDR <= a; I_WDATA <= d; I_XFER <= x;
    @(posedge I_CLK_SYS);
    I_WR <= 1'b0; I_XFER <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, exp, input logic x = 1'b0);
    @(posedge I_CLK_SYS);
    I_RD <= 1'b1; I_ADDR <= a; I_XFER <= x;
    @(posedge I_CLK_SYS);
    I_RD <= 1'b0; I_XFER <= 1'b0;
    #1;
    chk(O_RDATA, exp);
  endtask

  // one character, then the two-edge flag latency plus margin
  task automatic rx(input logic [7:0] b, input logic s, y);
    @(posedge I_CLK_SYS);
    send <= 1'b1; tx_byte <= b; stop <= s; sync <= y;
    @(posedge I_CLK_SYS);
    send <= 1'b0;
    repeat (200) begin
      @(posedge I_CLK_SYS);
      #1;
      if (!busy) break;
    end
    // a frame that never ends counts as a mismatch
    if (busy) begin
      n_fail++;
      $display("unexpected at %0t: line frame hung", $time);
    end
    repeat (3) @(posedge I_CLK_SYS);
    #1;
  endtask

  initial begin
    #100000;
    n_fail++;
    finish_test;
  end

  initial begin
    repeat (2) @(posedge I_CLK_SYS);
    I_RST <= 1'b0;
    rd(`SRSF_OFS_STAT, 8'h80);
    rd(`SRSF_OFS_CTRL, 8'h00);
    rd(8'hfc, 8'h00);
    chk({7'h0, O_IRQ}, 8'h00);
    wr(`SRSF_OFS_CTRL, 8'h03);
    rd(`SRSF_OFS_STAT, 8'h80);
    chk({7'h0, O_TX_REQ}, 8'h01);
    rx(8'ha5, 1'b1, 1'b0);
    wr(`SRSF_OFS_STAT, 8'h00);
    chk({7'h0, O_RX_REQ}, 8'h01);
    rd(`SRSF_OFS_STAT, 8'hc0);
    rd(`SRSF_OFS_RXD, 8'ha5);
    wr(`SRSF_OFS_STAT, 8'hf0);
    chk({7'h0, O_RX_REQ}, 8'h01);
    wr(`SRSF_OFS_STAT, 8'h80);
    chk({7'h0, O_RX_REQ}, 8'h00);
    rx(8'h3c, 1'b1, 1'b0);
    rd(`SRSF_OFS_RXD, 8'h3c, 1'b1);
    chk({7'h0, O_RX_REQ}, 8'h00);
    rx(8'h11, 1'b1, 1'b0);
    rx(8'h22, 1'b1, 1'b0);
    rd(`SRSF_OFS_STAT, 8'he0);
    rd(`SRSF_OFS_RXD, 8'h11, 1'b1);
    rx(8'h33, 1'b1, 1'b0);
    chk({7'h0, O_RX_REQ}, 8'h00);
    wr(`SRSF_OFS_IMASK, 8'h02);
    chk({7'h0, O_IRQ}, 8'h01);
    wr(`SRSF_OFS_ISTAT, 8'h02);
    chk({7'h0, O_IRQ}, 8'h00);
    wr(`SRSF_OFS_CTRL, 8'h01);
    rd(`SRSF_OFS_STAT, 8'ha0);
    wr(`SRSF_OFS_STAT, 8'h80);
    rd(`SRSF_OFS_STAT, 8'h80);
    wr(`SRSF_OFS_CTRL, 8'h03);
    rx(8'h5a, 1'b0, 1'b0);
    rd(`SRSF_OFS_STAT, 8'h90);
    chk({7'h0, O_RX_REQ}, 8'h00);
    wr(`SRSF_OFS_STAT, 8'h80);
    wr(`SRSF_OFS_CTRL, 8'h07);
    rx(8'h5a, 1'b1, 1'b1);
    rd(`SRSF_OFS_STAT, 8'hc0);
    rd(`SRSF_OFS_RXD, 8'h5a, 1'b1);
    wr(`SRSF_OFS_TXD, 8'hc1, 1'b1);
    chk({7'h0, O_TX_REQ}, 8'h00);
    repeat (2) @(posedge I_CLK_SYS);
    #1;
    chk({7'h0, O_TX_REQ}, 8'h01);
    // synchronous frame strobes shift the loaded byte out lsb first
    rx(8'h96, 1'b1, 1'b1);
    chk(txd_sh, 8'hc1);
    rx(8'h69, 1'b1, 1'b1);
    wr(`SRSF_OFS_TXD, 8'h3c, 1'b1);
    repeat (2) @(posedge I_CLK_SYS);
    #1;
    chk({7'h0, O_TX_REQ}, 8'h00);
    rd(`SRSF_OFS_STAT, 8'h60);
    rd(`SRSF_OFS_RXD, 8'h96);
    wr(`SRSF_OFS_STAT, 8'h80);
    repeat (2) @(posedge I_CLK_SYS);
    #1;
    chk({7'h0, O_TX_REQ}, 8'h01);
    wr(`SRSF_OFS_CTRL, 8'h06);
    rd(`SRSF_OFS_STAT, 8'h80);
    finish_test;
  end
endmodule
`default_nettype wire
